// File: src/msp_pkg.sv
`default_nettype none

package msp_pkg;

  // --------------------------------------------------------------------------
  // Clock and link timing
  // --------------------------------------------------------------------------

  // Core clock rate in hertz.
  localparam int CLK_HZ           = 250_000_000;
  // Selectable UART bit rates in bits per second.
  localparam int BAUD_FAST        = 38400;
  localparam int BAUD_MID         = 19200;
  localparam int BAUD_SLOW        = 9600;
  // Longest quiet time between two rising serial clock edges, in core clocks.
  localparam int SPI_TIMEOUT_CLKS = 32768;
  // Bits per UART character, one idle bit time appended as the byte gap.
  localparam logic [3:0] UART_CHAR_BITS = 4'hB;
  // Bytes in a reply beyond the register data: the checksum.
  localparam logic [1:0] CSUM_BYTES     = 2'h1;

  // --------------------------------------------------------------------------
  // Frame bytes and special commands
  // --------------------------------------------------------------------------

  localparam logic [7:0] SYNC_BYTE   = 8'hA5;
  localparam logic [7:0] SPECIAL_CMD = 8'hEA;
  localparam logic [7:0] SPC_WR_EN   = 8'hE5;
  localparam logic [7:0] SPC_WR_PROT = 8'hDC;
  localparam logic [7:0] SPC_CHAN_A  = 8'h5A;
  localparam logic [7:0] SPC_CHAN_B  = 8'hA5;
  localparam logic [7:0] SPC_RESET   = 8'h96;
  // Position of the direction bit in a command byte.
  localparam int         CMD_DIR_BIT = 7;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------

  localparam logic [6:0]  PULSE_FREQ_ADDR  = 7'h02;
  localparam logic [1:0]  PULSE_FREQ_BYTES = 2'h2;
  localparam logic [15:0] PULSE_FREQ_RESET = 16'h0000;

  // Frame parser states.
  typedef enum logic [2:0] {
    ST_SYNC, ST_CMD, ST_SPEC, ST_DATA, ST_CSUM, ST_REPLY
  } msp_state_t;

  // Width in bytes of the register at an address; zero for unknown addresses.
  function automatic logic [1:0] msp_reg_bytes(input logic [6:0] addr);
    return (addr == PULSE_FREQ_ADDR) ? PULSE_FREQ_BYTES : 2'h0;
  endfunction : msp_reg_bytes

endpackage : msp_pkg

`default_nettype wire

// File: src/msp_port.sv
// Summary of operation
// RL1 - SPI host: select low, command, data bytes.
// RL2 - Bits and bytes travel most significant first.
// RL3 - SPI input sampled on falling serial clock.
// RL4 - Host keeps half-period gaps around bytes.
// RL5 - Protected writes ignored until write enable.
// RL6 - Strap low gives UART, high gives SPI.
// RL7 - Clock and select pins choose baud rate.
// RL8 - Half-duplex slave; transmits only for reads.
// RL9 - Character: start, 8 data LSB first, parity, stop.
// RL10 - Even parity; mismatch is a byte error.
// RL11 - UART frame opens with sync byte then command.
// RL12 - Command bit 7 is direction, rest address.
// RL13 - Special command enables or closes writes.
// RL14 - Special data selects current channel A or B.
// RL15 - Special data 0x96 resets the whole device.
// RL16 - Checksum is inverted eight-bit byte sum.
// RL17 - UART write applied only on matching checksum.
// RL18 - Parity error in write drops current frame.
// RL19 - Parity error ends the current frame.
// RL20 - No timeout between UART bytes or frames.
// RL21 - Read reply: register bytes then checksum.
// RL22 - First reply byte starts half bit later.
// RL23 - One idle bit between reply bytes.
// RL24 - Byte count from register width; unknown silent.
// RL25 - SPI logic resets after long clock silence.
`timescale 1ns/1ns
`default_nettype none

module msp_port
  import msp_pkg::*;
#(
  parameter int BIT_CYC_FAST    = CLK_HZ / BAUD_FAST,
  parameter int BIT_CYC_MID     = CLK_HZ / BAUD_MID,
  parameter int BIT_CYC_SLOW    = CLK_HZ / BAUD_SLOW,
  parameter int SPI_TIMEOUT_CYC = SPI_TIMEOUT_CLKS,
  parameter int BUF_DEPTH       = 2
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Straps and serial pins.
  input  wire logic        interface_select_strap,
  input  wire logic        serial_clk_pin,
  input  wire logic        chip_select_n,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             serial_out_oe,
  // Device controls.
  output logic [15:0]      pulse_frequency_constant,
  output logic             write_enabled,
  output logic             channel_b_selected,
  output logic             device_reset_req,
  output logic             frame_error
);

  // --------------------------------------------------------------------------
  // Mode and bit timing
  // --------------------------------------------------------------------------

  localparam logic [15:0] CYC_FAST = 16'(BIT_CYC_FAST);
  localparam logic [15:0] CYC_MID  = 16'(BIT_CYC_MID);
  localparam logic [15:0] CYC_SLOW = 16'(BIT_CYC_SLOW);
  localparam logic [15:0] SPI_TO   = 16'(SPI_TIMEOUT_CYC);
  localparam int          PW       = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam logic [PW:0] BUF_FULL = (PW + 1)'(BUF_DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(BUF_DEPTH - 1);

  logic        uart_mode;
  logic [15:0] bit_cyc;
  logic [15:0] half_cyc;

  // The straps are static in a real board, so they are read live.
  assign uart_mode = ~interface_select_strap;  // see RL6

  // Baud selection; both unlisted combinations fall back to the slowest rate.
  always_comb begin
    unique case ({serial_clk_pin, chip_select_n})  // see RL7
      2'b11:   bit_cyc = CYC_FAST;
      2'b01:   bit_cyc = CYC_MID;
      default: bit_cyc = CYC_SLOW;
    endcase
  end
  assign half_cyc = bit_cyc >> 1;

  // --------------------------------------------------------------------------
  // UART receiver
  // --------------------------------------------------------------------------

  logic        rx_busy;
  logic [3:0]  rx_bit;
  logic [15:0] rx_tmr;
  logic [8:0]  rx_sr;
  logic        rx_done;

  // Each bit is sampled mid-cell; no timeout, the line may idle forever.
  always_ff @(posedge core_clk) begin  // see RL20
    if (srst || !uart_mode) begin
      rx_busy <= 1'b0;
      rx_bit  <= 4'h0;
      rx_tmr  <= 16'h0000;
      rx_sr   <= 9'h000;
    end else if (!rx_busy) begin
      if (!serial_in_pin) begin
        rx_busy <= 1'b1;
        rx_bit  <= 4'h0;
        rx_tmr  <= half_cyc;
      end
    end else if (rx_tmr != 16'h0000) begin
      rx_tmr <= rx_tmr - 16'h0001;
    end else begin
      rx_tmr <= bit_cyc - 16'h0001;
      rx_bit <= rx_bit + 4'h1;
      // A start bit that is high again at mid-cell was a glitch.
      if ((rx_bit == 4'h0) && serial_in_pin) begin
        rx_busy <= 1'b0;
      end
      // Data arrive least significant first, then the parity bit.
      if ((rx_bit != 4'h0) && (rx_bit != (UART_CHAR_BITS - 4'h1))) begin  // see RL9
        rx_sr <= {serial_in_pin, rx_sr[8:1]};
      end
      if (rx_bit == (UART_CHAR_BITS - 4'h1)) begin
        rx_busy <= 1'b0;
      end
    end
  end
  assign rx_done = rx_busy && (rx_tmr == 16'h0000) && (rx_bit == (UART_CHAR_BITS - 4'h1));

  // --------------------------------------------------------------------------
  // SPI write receiver
  // --------------------------------------------------------------------------

  logic        sclk_q;
  logic        spi_active;
  logic        sclk_rise;
  logic        sclk_fall;
  logic [2:0]  spi_cnt;
  logic [7:0]  spi_sr;
  logic [15:0] spi_idle;
  logic        spi_timeout;
  logic        spi_done;

  assign spi_active  = !uart_mode && !chip_select_n;  // see RL1
  assign sclk_rise   = !sclk_q && serial_clk_pin;
  assign sclk_fall   = sclk_q && !serial_clk_pin;
  assign spi_timeout = spi_active && (spi_idle >= SPI_TO);

  // Previous serial clock level for edge detection.
  always_ff @(posedge core_clk) begin
    sclk_q <= srst ? 1'b0 : serial_clk_pin;
  end

  // The host shifts on rising edges, so the input is settled at the fall.
  always_ff @(posedge core_clk) begin
    if (srst || !spi_active || spi_timeout) begin  // see RL25
      spi_cnt  <= 3'h0;
      spi_sr   <= 8'h00;
      spi_idle <= 16'h0000;
    end else begin
      spi_idle <= sclk_rise ? 16'h0000 : spi_idle + 16'h0001;
      if (sclk_fall) begin  // see RL3
        spi_sr  <= {spi_sr[6:0], serial_in_pin};  // see RL2
        spi_cnt <= spi_cnt + 3'h1;
      end
    end
  end
  assign spi_done = spi_active && !spi_timeout && sclk_fall && (spi_cnt == 3'h7);

  // --------------------------------------------------------------------------
  // Two-entry byte buffer
  // --------------------------------------------------------------------------

  logic          buf_in_valid;
  logic          buf_in_ready;
  logic [8:0]    buf_in_data;
  logic          buf_out_valid;
  logic          buf_out_ready;
  logic [8:0]    buf_mem [BUF_DEPTH];
  logic [PW-1:0] buf_wp;
  logic [PW-1:0] buf_rp;
  logic [PW:0]   buf_cnt;
  logic          buf_flush;
  logic          overrun;

  // Even parity over data plus parity bit must come out zero; a low stop bit
  // is also a byte error. Bit 8 of an entry marks a bad byte.
  assign buf_in_valid = rx_done || spi_done;
  assign buf_in_data  = uart_mode ? {(^rx_sr) | !serial_in_pin, rx_sr[7:0]}  // see RL10
                                  : {1'b0, spi_sr[6:0], serial_in_pin};
  assign buf_in_ready  = buf_cnt != BUF_FULL;
  assign buf_out_valid = buf_cnt != '0;
  assign buf_flush     = !uart_mode && (chip_select_n || spi_timeout);

  // The parser stalls while replying; a byte arriving against a full buffer
  // cannot be held back on the wire, so it marks the frame as broken.
  always_ff @(posedge core_clk) begin
    if (srst || buf_flush) begin
      buf_wp  <= '0;
      buf_rp  <= '0;
      buf_cnt <= '0;
    end else begin
      if (buf_in_valid && buf_in_ready) begin
        buf_mem[buf_wp] <= buf_in_data;
        buf_wp          <= (buf_wp == PTR_LAST) ? '0 : buf_wp + 1'b1;
      end
      if (buf_out_valid && buf_out_ready) begin
        buf_rp <= (buf_rp == PTR_LAST) ? '0 : buf_rp + 1'b1;
      end
      buf_cnt <= buf_cnt + (PW + 1)'(buf_in_valid && buf_in_ready)
                         - (PW + 1)'(buf_out_valid && buf_out_ready);
    end
  end

  // Lost byte marker, seen by the parser one cycle later.
  always_ff @(posedge core_clk) begin
    overrun <= !srst && buf_in_valid && !buf_in_ready;
  end

  // --------------------------------------------------------------------------
  // Frame parser
  // --------------------------------------------------------------------------

  msp_state_t  state;
  logic [7:0]  cmd;
  logic [7:0]  sum;
  logic [15:0] data;
  logic [1:0]  left;
  logic        take;
  logic        bad;
  logic [7:0]  b;
  logic        is_special;
  logic        do_commit;
  logic [15:0] commit_val;
  logic        tx_start;
  logic        tx_done;
  logic [7:0]  cmd_sum;
  msp_state_t  restart;

  assign buf_out_ready = state != ST_REPLY;  // see RL8
  assign take          = buf_out_valid && buf_out_ready;
  assign b             = buf_mem[buf_rp][7:0];
  assign bad           = buf_mem[buf_rp][8];
  assign is_special    = cmd == SPECIAL_CMD;
  assign restart       = uart_mode ? ST_SYNC : ST_CMD;
  assign cmd_sum       = sum + b;
  // SPI frames carry no checksum, so they commit on the last data byte.
  assign do_commit = take && !bad &&
      ((uart_mode && (state == ST_CSUM) && (b == ~sum)) ||  // see RL16, RL17
       (!uart_mode && ((state == ST_SPEC) || ((state == ST_DATA) && (left == 2'h1)))));
  assign commit_val = uart_mode ? data : {data[7:0], b};
  // A read of an unknown address draws no reply at all.
  assign tx_start = take && !bad && uart_mode && (state == ST_CMD) && !b[CMD_DIR_BIT] &&
                    (msp_reg_bytes(b[6:0]) != 2'h0);  // see RL21, RL24

  // Byte-level frame walk; sums run from the sync byte with carries dropped.
  always_ff @(posedge core_clk) begin
    if (srst || overrun || buf_flush) begin
      state <= restart;
      cmd   <= 8'h00;
      sum   <= 8'h00;
      data  <= 16'h0000;
      left  <= 2'h0;
    end else if (state == ST_REPLY) begin
      if (tx_done) begin
        state <= ST_SYNC;
      end
    end else if (take) begin
      if (bad) begin
        state <= restart;  // see RL18, RL19
      end else begin
        unique case (state)
          ST_SYNC: begin
            if (b == SYNC_BYTE) begin  // see RL11
              state <= ST_CMD;
              sum   <= SYNC_BYTE;
            end
          end
          ST_CMD: begin
            cmd  <= b;
            sum  <= cmd_sum;
            data <= 16'h0000;
            left <= msp_reg_bytes(b[6:0]);
            if (b == SPECIAL_CMD) begin  // see RL13
              state <= ST_SPEC;
            end else if (b[CMD_DIR_BIT]) begin  // see RL12
              state <= (msp_reg_bytes(b[6:0]) == 2'h0) ? restart : ST_DATA;
            end else begin
              state <= tx_start ? ST_REPLY : restart;
            end
          end
          ST_SPEC: begin
            data  <= {data[7:0], b};
            sum   <= cmd_sum;
            state <= uart_mode ? ST_CSUM : restart;
          end
          ST_DATA: begin
            data <= {data[7:0], b};  // see RL2
            sum  <= cmd_sum;
            left <= left - 2'h1;
            if (left == 2'h1) begin
              state <= uart_mode ? ST_CSUM : restart;
            end
          end
          ST_CSUM: state <= ST_SYNC;
          ST_REPLY: state <= ST_REPLY;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Configuration state
  // --------------------------------------------------------------------------

  // Write protection guards the register; special commands always pass.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      write_enabled            <= 1'b0;
      channel_b_selected       <= 1'b0;
      pulse_frequency_constant <= PULSE_FREQ_RESET;
    end else if (do_commit && is_special) begin
      unique case (commit_val[7:0])
        SPC_WR_EN:   write_enabled      <= 1'b1;  // see RL13
        SPC_WR_PROT: write_enabled      <= 1'b0;
        SPC_CHAN_A:  channel_b_selected <= 1'b0;  // see RL14
        SPC_CHAN_B:  channel_b_selected <= 1'b1;
        default:     write_enabled      <= write_enabled;
      endcase
    end else if (do_commit && write_enabled && (cmd[6:0] == PULSE_FREQ_ADDR)) begin  // see RL5
      pulse_frequency_constant <= commit_val;
    end
  end

  // The reset request is a pulse; the device reset returns through srst.
  always_ff @(posedge core_clk) begin
    device_reset_req <= !srst && do_commit && is_special && (commit_val[7:0] == SPC_RESET);  // see RL15
    frame_error      <= !srst && (overrun || (take && bad) ||
                        (take && uart_mode && (state == ST_CSUM) && (b != ~sum)));
  end

  // --------------------------------------------------------------------------
  // UART reply transmitter
  // --------------------------------------------------------------------------

  logic [23:0] tx_q;
  logic [1:0]  tx_nbytes;
  logic [10:0] tx_sr;
  logic [3:0]  tx_bit;
  logic [15:0] tx_tmr;
  logic        tx_line;
  logic [7:0]  tx_csum;

  assign tx_csum = ~(cmd_sum + pulse_frequency_constant[15:8] + pulse_frequency_constant[7:0]);
  assign tx_done = (tx_nbytes == 2'h0) && (tx_bit == 4'h0) && (tx_tmr == 16'h0000);

  // The command byte is taken mid-stop-bit, so one bit time puts the first
  // start edge half a bit after the stop ends. Each character carries a
  // trailing idle bit that forms the gap between reply bytes.
  always_ff @(posedge core_clk) begin
    if (srst || !uart_mode) begin
      tx_q      <= 24'h000000;
      tx_nbytes <= 2'h0;
      tx_sr     <= 11'h7FF;
      tx_bit    <= 4'h0;
      tx_tmr    <= 16'h0000;
      tx_line   <= 1'b1;
    end else if (tx_start) begin
      tx_q      <= {pulse_frequency_constant, tx_csum};  // see RL21
      tx_nbytes <= PULSE_FREQ_BYTES + CSUM_BYTES;
      tx_tmr    <= bit_cyc - 16'h0001;  // see RL22
    end else if (tx_tmr != 16'h0000) begin
      tx_tmr <= tx_tmr - 16'h0001;
    end else if (tx_bit != 4'h0) begin
      tx_line <= tx_sr[0];
      tx_sr   <= {1'b1, tx_sr[10:1]};
      tx_bit  <= tx_bit - 4'h1;
      tx_tmr  <= bit_cyc - 16'h0001;
    end else if (tx_nbytes != 2'h0) begin
      tx_line   <= 1'b0;
      tx_sr     <= {2'b11, ^tx_q[23:16], tx_q[23:16]};  // see RL9, RL23
      tx_bit    <= UART_CHAR_BITS;  // Ten character bits plus the idle gap bit.
      tx_tmr    <= bit_cyc - 16'h0001;
      tx_q      <= {tx_q[15:0], 8'h00};  // see RL2
      tx_nbytes <= tx_nbytes - 2'h1;
    end
  end

  assign serial_out_pin = tx_line;
  assign serial_out_oe  = uart_mode;  // see RL6

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_reply_lead: assert property ($rose(state == ST_REPLY) |-> tx_line [*8])  // see RL22
    else $error("Reply started too early.");
  a_tx_quiet: assert property ((state != ST_REPLY) && $past(state != ST_REPLY) |-> tx_line)  // see RL8
    else $error("Transmit line active outside a reply.");
  a_write_open: assert property (do_commit && is_special && (commit_val[7:0] == SPC_WR_EN)
                                 |=> write_enabled)  // see RL13
    else $error("Write enable command not applied.");
  a_write_guard: assert property ($changed(pulse_frequency_constant) |-> $past(write_enabled))  // see RL5
    else $error("Protected register written while locked.");
  a_chan_b: assert property (do_commit && is_special && (commit_val[7:0] == SPC_CHAN_B)
                             |=> channel_b_selected)  // see RL14
    else $error("Channel B select not applied.");
  a_reset_cause: assert property (device_reset_req |-> $past(do_commit && is_special &&
                                  (commit_val[7:0] == SPC_RESET)))  // see RL15
    else $error("Reset request without reset command.");
  a_parity_drop: assert property (take && bad && uart_mode && !overrun |=> state == ST_SYNC)  // see RL18
    else $error("Bad byte did not drop the frame.");
  a_csum_gate: assert property ($changed(pulse_frequency_constant) && $past(uart_mode)
                                |-> $past((state == ST_CSUM) && (b == ~sum)))  // see RL17
    else $error("UART write applied without a good checksum.");
  a_cmd_write: assert property (take && !bad && !overrun && !buf_flush && (state == ST_CMD) &&
                                b[CMD_DIR_BIT] && (b != SPECIAL_CMD) &&
                                (msp_reg_bytes(b[6:0]) != 2'h0) |=> state == ST_DATA)  // see RL12
    else $error("Write command did not enter data phase.");
  a_spi_timeout: assert property (spi_timeout |=> (spi_cnt == 3'h0) && (spi_idle == 16'h0000))  // see RL25
    else $error("SPI logic not reset after clock silence.");

endmodule : msp_port

`default_nettype wire

// File: sim/msp_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------------
// Host controller model
// ----------------------------------------------------------------------------

module msp_host_model (
  // Clock.
  input  wire logic core_clk,
  // Straps and serial pins.
  output logic      interface_select_strap,
  output logic      serial_clk_pin,
  output logic      chip_select_n,
  output logic      serial_in_pin,
  input  wire logic serial_out_pin
);
  int bit_cyc;

  // Pins start in UART mode at the fast rate with the receive line idle high.
  initial begin
    interface_select_strap = 1'b0;
    serial_clk_pin         = 1'b1;
    chip_select_n          = 1'b1;
    serial_in_pin          = 1'b1;
    bit_cyc                = 16;
  end

  // Waits n rising edges and steps just past the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  // Sets straps and pins; straps only move while the line is idle.
  task automatic set_pins(input logic strap, input logic sclk, input logic csn, input int t);
    interface_select_strap = strap;
    serial_clk_pin         = sclk;
    chip_select_n          = csn;
    bit_cyc                = t;
    tick(4);
  endtask : set_pins

  // Sends one character; bad_par flips the parity bit on purpose.
  task automatic uart_send(input logic [7:0] b, input logic bad_par);
    logic [10:0] ch;
    ch = {1'b1, ^b ^ bad_par, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      serial_in_pin = ch[i];
      tick(bit_cyc);
    end
  endtask : uart_send

  // Receives one character, counting idle cycles before its start bit.
  task automatic uart_recv(output logic [7:0] b, output logic ok, output int gap);
    logic [10:0] ch;
    gap = 0;
    ch  = '0;
    while (serial_out_pin === 1'b1 && gap < 4 * bit_cyc) begin
      tick(1);
      gap++;
    end
    ok = (serial_out_pin === 1'b0);
    if (ok) begin
      tick(bit_cyc / 2);
      for (int i = 0; i < 11; i++) begin
        ch[i] = serial_out_pin;
        if (i < 10) tick(bit_cyc);
      end
    end
    b  = ch[8:1];
    ok = ok && ch[0] === 1'b0 && ch[10] === 1'b1 && (^ch[9:1]) === 1'b0;
  endtask : uart_recv

  // Shifts the top n bits of b, changing data with the clock's rise.
  task automatic spi_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      serial_clk_pin = 1'b1;
      serial_in_pin  = b[i];
      tick(4);
      serial_clk_pin = 1'b0;
      tick(4);
    end
    tick(4);
    serial_in_pin = ~serial_in_pin;
  endtask : spi_bits

endmodule : msp_host_model

`default_nettype wire

// File: sim/meter_serial_host_port_tb.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------------
// Serial host port testbench
// ----------------------------------------------------------------------------

module meter_serial_host_port_tb;
  import msp_pkg::*;
  localparam int T_FAST = 16;
  localparam int T_MID  = 32;
  localparam int T_SLOW = 64;

  logic        core_clk;
  logic        srst;
  wire logic   strap;
  wire logic   sclk;
  wire logic   csn;
  wire logic   sin;
  logic        serial_out_pin;
  logic        serial_out_oe;
  logic [15:0] pfc;
  logic        write_enabled;
  logic        channel_b_selected;
  logic        device_reset_req;
  logic        frame_error;
  int          n_fail      = 0;
  int          comparisons = 0;
  int          n_ferr      = 0;
  int          n_rst       = 0;
  int          bt[3]       = '{T_FAST, T_MID, T_SLOW};
  logic [1:0]  bs[3]       = '{2'b11, 2'b01, 2'b10};

  msp_port #(.BIT_CYC_FAST(T_FAST), .BIT_CYC_MID(T_MID), .BIT_CYC_SLOW(T_SLOW),
    .SPI_TIMEOUT_CYC(200), .BUF_DEPTH(2)) uut (
    .core_clk(core_clk), .srst(srst), .interface_select_strap(strap),
    .serial_clk_pin(sclk), .chip_select_n(csn), .serial_in_pin(sin),
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
    .pulse_frequency_constant(pfc), .write_enabled(write_enabled),
    .channel_b_selected(channel_b_selected), .device_reset_req(device_reset_req),
    .frame_error(frame_error));

  msp_host_model host (
    .core_clk(core_clk), .interface_select_strap(strap), .serial_clk_pin(sclk),
    .chip_select_n(csn), .serial_in_pin(sin), .serial_out_pin(serial_out_pin));

  // Free-running 4 ns clock.
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Pulses last one cycle, so they are counted rather than sampled later.
  always @(posedge core_clk) begin
    if (frame_error === 1'b1) n_ferr++;
    if (device_reset_req === 1'b1) n_rst++;
  end

  task automatic give_verdict();
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Sends sync, the given bytes and, if asked, the inverted byte sum.
  task automatic send_frame(input logic [7:0] q[$], input logic add_cs);
    logic [7:0] s;
    s = SYNC_BYTE;
    host.uart_send(SYNC_BYTE, 1'b0);
    foreach (q[i]) begin
      host.uart_send(q[i], 1'b0);
      s = s + q[i];
    end
    if (add_cs) host.uart_send(~s, 1'b0);
    host.tick(4);
  endtask : send_frame

  // Reads the 16-bit register and checks bytes, checksum and spacing.
  task automatic rd_check(input logic [15:0] exp, input int t);
    logic [7:0] b;
    logic [7:0] s;
    logic       ok;
    int         gap;
    int         lo;
    host.uart_send(SYNC_BYTE, 1'b0);
    host.uart_send({1'b0, PULSE_FREQ_ADDR}, 1'b0);
    s = ~(SYNC_BYTE + {1'b0, PULSE_FREQ_ADDR} + exp[15:8] + exp[7:0]);
    for (int i = 0; i < 3; i++) begin
      host.uart_recv(b, ok, gap);
      chk({7'h0, ok, b}, {8'h01, (i == 0) ? exp[15:8] : (i == 1) ? exp[7:0] : s});
      if (ok !== 1'b1) give_verdict();
      lo = (i == 0) ? t / 2 - 2 : 3 * t / 2 - 3;
      chk({15'h0, gap >= lo && gap <= lo + 8}, 16'h0001);
    end
  endtask : rd_check

  // Main sequence.
  initial begin
    logic [7:0] b;
    logic       ok;
    int         gap;
    srst = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 srst = 1'b0;
    host.tick(2);
    chk(pfc, PULSE_FREQ_RESET);
    chk({12'h0, serial_out_pin, serial_out_oe, write_enabled, channel_b_selected}, 16'h000C);
    send_frame('{8'h82, 8'h12, 8'h34}, 1'b1);
    chk(pfc, 16'h0000);
    send_frame('{SPECIAL_CMD, SPC_WR_EN}, 1'b1);
    chk({15'h0, write_enabled}, 16'h0001);
    send_frame('{8'h82, 8'h12, 8'h34, 8'h93}, 1'b0);
    chk({pfc[7:0], n_ferr[7:0]}, 16'h0001);
    host.uart_send(SYNC_BYTE, 1'b1);
    send_frame('{8'h82, 8'hAB, 8'hCD}, 1'b1);
    chk(pfc, 16'hABCD);
    chk(n_ferr[15:0], 16'h0002);
    for (int i = 0; i < 3; i++) begin
      host.set_pins(1'b0, bs[i][1], bs[i][0], bt[i]);
      rd_check(16'hABCD, bt[i]);
    end
    send_frame('{8'h05}, 1'b0);
    host.uart_recv(b, ok, gap);
    chk({15'h0, ok}, 16'h0000);
    send_frame('{SPECIAL_CMD, SPC_CHAN_B}, 1'b1);
    chk({15'h0, channel_b_selected}, 16'h0001);
    send_frame('{SPECIAL_CMD, SPC_CHAN_A}, 1'b1);
    chk({15'h0, channel_b_selected}, 16'h0000);
    send_frame('{SPECIAL_CMD, SPC_RESET}, 1'b1);
    chk(n_rst[15:0], 16'h0001);
    send_frame('{SPECIAL_CMD, SPC_WR_PROT}, 1'b1);
    chk({15'h0, write_enabled}, 16'h0000);
    // Switch to SPI: clock idles low, select opens the frame.
    host.set_pins(1'b1, 1'b0, 1'b1, T_FAST);
    chk({15'h0, serial_out_oe}, 16'h0000);
    host.set_pins(1'b1, 1'b0, 1'b0, T_FAST);
    host.spi_bits(SPECIAL_CMD, 8);
    host.spi_bits(SPC_WR_EN, 8);
    host.spi_bits(8'h82, 8);
    host.spi_bits(8'h56, 8);
    host.spi_bits(8'h78, 8);
    host.set_pins(1'b1, 1'b0, 1'b1, T_FAST);
    chk(pfc, 16'h5678);
    // Half a byte, then a silence past the limit must flush it.
    host.set_pins(1'b1, 1'b0, 1'b0, T_FAST);
    host.spi_bits(8'hFF, 4);
    host.tick(250);
    host.spi_bits(8'h82, 8);
    host.spi_bits(8'h9A, 8);
    host.spi_bits(8'hBC, 8);
    host.set_pins(1'b1, 1'b0, 1'b1, T_FAST);
    chk(pfc, 16'h9ABC);
    give_verdict();
  end

endmodule : meter_serial_host_port_tb

`default_nettype wire
